// >>> src/ipr_defines.vh
// Register offsets, field positions, reset values and masks for the priority register bank
`ifndef IPR_DEFINES_VH
`define IPR_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IPR_OFF_CTRL0 5'h00
`define IPR_OFF_CTRL1 5'h04
`define IPR_OFF_CTRL2 5'h08
`define IPR_OFF_CTRL3 5'h0C
`define IPR_OFF_CTRL4 5'h10
`define IPR_OFF_CTRL5 5'h14
`define IPR_NUM_REGS 6

// ----------------------------------------------------------------
// Field positions (low bit of each 3-bit field)
// ----------------------------------------------------------------
`define IPR_FLD_HI 4'hC
`define IPR_FLD_MH 4'h8
`define IPR_FLD_ML 4'h4
`define IPR_FLD_LO 4'h0
`define IPR_FLD_W 3

// ----------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------
`define IPR_FLD_RESET 3'h4
`define IPR_RST_CTRL0 16'h4444
`define IPR_RST_CTRL1 16'h4440
`define IPR_RST_CTRL2 16'h4444
`define IPR_RST_CTRL3 16'h0044
`define IPR_RST_CTRL4 16'h4444
`define IPR_RST_CTRL5 16'h0004
`define IPR_MSK_CTRL0 16'h7777
`define IPR_MSK_CTRL1 16'h7770
`define IPR_MSK_CTRL2 16'h7777
`define IPR_MSK_CTRL3 16'h0077
`define IPR_MSK_CTRL4 16'h7777
`define IPR_MSK_CTRL5 16'h0007

// ----------------------------------------------------------------
// Priority level codes
// ----------------------------------------------------------------
`define IPR_LVL_OFF 3'h0
`define IPR_LVL_MIN 3'h1
`define IPR_LVL_MAX 3'h7

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define IPR_RESP_OKAY 2'h0
`define IPR_RESP_SLVERR 2'h2

`endif

// >>> src/ipr_reg_mem.v
// Six-word priority register store with masked write and registered read data
`timescale 1ns/1ps
`include "ipr_defines.vh"

module ipr_reg_mem #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [WIDTH-1:0] wr_data,
  input wire [WIDTH-1:0] wr_strb_mask,
  input wire rd_en,
  input wire [2:0] rd_idx,
  output reg [WIDTH-1:0] rd_data,
  output wire [6*WIDTH-1:0] all_words
);

  reg [WIDTH-1:0] word_reg [0:5];

  // ----------------------------------------------------------------
  // Per-register implemented-bit mask
  // ----------------------------------------------------------------
  function [WIDTH-1:0] impl_mask;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: impl_mask = `IPR_MSK_CTRL0;
        3'h1: impl_mask = `IPR_MSK_CTRL1;
        3'h2: impl_mask = `IPR_MSK_CTRL2;
        3'h3: impl_mask = `IPR_MSK_CTRL3;
        3'h4: impl_mask = `IPR_MSK_CTRL4;
        3'h5: impl_mask = `IPR_MSK_CTRL5;
        default: impl_mask = {WIDTH{1'b0}};
      endcase
    end
  endfunction

  // Storage; reserved bits are never stored, so they always read zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      word_reg[0] <= `IPR_RST_CTRL0; // [RULE_04]
      word_reg[1] <= `IPR_RST_CTRL1; // [RULE_04]
      word_reg[2] <= `IPR_RST_CTRL2; // [RULE_04]
      word_reg[3] <= `IPR_RST_CTRL3; // [RULE_04]
      word_reg[4] <= `IPR_RST_CTRL4; // [RULE_04]
      word_reg[5] <= `IPR_RST_CTRL5; // [RULE_04]
    end else if (wr_en && wr_idx < 3'h6) begin
      // Bytes not strobed and unimplemented bits keep their value
      word_reg[wr_idx] <= (word_reg[wr_idx] & ~(wr_strb_mask & impl_mask(wr_idx))) |
                          (wr_data & wr_strb_mask & impl_mask(wr_idx)); // [RULE_12] [RULE_14]
    end
  end

  // Registered read port
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= {WIDTH{1'b0}};
    end else if (rd_en) begin
      if (rd_idx < 3'h6) begin
        rd_data <= word_reg[rd_idx] & impl_mask(rd_idx); // [RULE_05]
      end else begin
        rd_data <= {WIDTH{1'b0}};
      end
    end
  end

  assign all_words = {word_reg[5], word_reg[4], word_reg[3],
                      word_reg[2], word_reg[1], word_reg[0]};

endmodule

// >>> src/ipr_top.v
// AXI4-Lite priority register bank feeding per-source levels to arbitration
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ipr_defines.vh"

// How it works
// RULE_01 - Each source has a 3-bit priority field; 111 means level 7, highest.
// RULE_02 - Field value 001 means level 1, lowest level that still requests.
// RULE_03 - Field value 000 disables the source; it never raises a request.
// RULE_04 - Reset loads every implemented field with 100, level 4.
// RULE_05 - Unimplemented bits always read as zero.
// RULE_06 - Register 0: timer1 14-12, compare1 10-8, capture1 6-4, ext irq0 2-0.
// RULE_07 - Register 1: timer2 14-12, compare2 10-8, capture2 6-4; bits 3-0 unused.
// RULE_08 - Register 2: serial1 rx 14-12, SPI1 event 10-8, SPI1 fault 6-4, timer3 2-0.
// RULE_09 - Register 3: ADC done 6-4, serial1 tx 2-0; bits 15-7 unused.
// RULE_10 - Register 4: pin change 14-12, comparator 10-8, I2C1 master 6-4, slave 2-0.
// RULE_11 - Register 5: ext irq1 in bits 2-0 only; bits 15-3 unused.
// RULE_12 - Implemented field bits are read/write; reads return last write or reset.
// RULE_13 - Values 010 to 110 are levels 2 to 6; larger value, higher priority.
// RULE_14 - Levels are presented continuously; writes to unused bits are ignored.

// ----------------------------------------------------------------
// Bus timing
// ----------------------------------------------------------------
// Write: address and data may arrive in either order or together.
// The store updates on the edge after the later handshake, with bvalid.
// Level outputs and enable flags follow one edge later still.
// Read: fetch on the edge after the address handshake, load the answer
// on the next, so rvalid rises two edges after the handshake.
// Only one write and one read are in flight; each ready stays low until
// its response has been taken, which keeps the store free of races.
// Misaligned or out-of-range addresses answer SLVERR and change nothing.
// Protection bits, the upper data half and the upper strobes are ignored.

module ipr_top #(
  parameter ADDR_W = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [2:0] timer1_prio,
  output reg [2:0] compare1_prio,
  output reg [2:0] capture1_prio,
  output reg [2:0] ext_irq0_prio,
  output reg [2:0] timer2_prio,
  output reg [2:0] compare2_prio,
  output reg [2:0] capture2_prio,
  output reg [2:0] serial1_rx_prio,
  output reg [2:0] spi_port1_event_prio,
  output reg [2:0] spi_port1_fault_prio,
  output reg [2:0] timer3_prio,
  output reg [2:0] adc_done_prio,
  output reg [2:0] serial1_tx_prio,
  output reg [2:0] pin_change_prio,
  output reg [2:0] comparator_prio,
  output reg [2:0] i2c_port1_master_prio,
  output reg [2:0] i2c_port1_slave_prio,
  output reg [2:0] ext_irq1_prio,
  output reg [17:0] source_enabled
);

  // ----------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------
  // Read sequence: accept, fetch from the store, load the answer, wait for rready
  localparam RD_IDLE = 2'h0;
  localparam RD_FETCH = 2'h1;
  localparam RD_RESP = 2'h2;
  localparam RD_LOAD = 2'h3;

  // Held halves of a write, read sequence state and the captured read address
  reg aw_held_reg;
  reg w_held_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [1:0] rd_state_reg;
  reg [1:0] rd_state_next;
  reg rd_err_reg;
  reg [ADDR_W-1:0] ar_addr_reg;

  // Store read port, packed image of all six words and the decoded requests
  wire [15:0] mem_rd_data;
  wire [95:0] words;
  wire wr_fire;
  wire wr_hit;
  wire [2:0] wr_idx;
  wire rd_hit;
  wire [2:0] rd_idx;

  // ----------------------------------------------------------------
  // Address decode, shared by both channels
  // ----------------------------------------------------------------
  function addr_hit;
    input [ADDR_W-1:0] addr;
    begin
      addr_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] < 3'h6);
    end
  endfunction

  function [2:0] addr_idx;
    input [ADDR_W-1:0] addr;
    begin
      addr_idx = addr[4:2];
    end
  endfunction

  // Field of a packed word by register and position
  function [2:0] fld;
    input [95:0] all;
    input [2:0] reg_i;
    input [3:0] lsb;
    begin
      fld = all[reg_i*16 + lsb +: 3];
    end
  endfunction

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  // A write fires once both halves are held and no response is pending
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_hit = addr_hit(aw_addr_reg);
  assign wr_idx = addr_idx(aw_addr_reg);

  // Each ready drops once its item is held, stalling the master until the response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      // Store update and response share one edge
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel: one cycle to fetch from the store, then answer
  // ----------------------------------------------------------------
  // Read decode works on the address captured at the handshake
  assign rd_hit = addr_hit(ar_addr_reg);
  assign rd_idx = addr_idx(ar_addr_reg);

  // Next state of the read sequence
  always @* begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          rd_state_next = RD_FETCH;
        end
      end
      RD_FETCH: rd_state_next = RD_LOAD;
      RD_LOAD: rd_state_next = RD_RESP;
      RD_RESP: begin
        if (s_axi_rready) begin
          rd_state_next = RD_IDLE;
        end
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  // Read data register reflects the store; upper half is always zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      ar_addr_reg <= {ADDR_W{1'b0}};
      rd_err_reg <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `IPR_RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      s_axi_arready <= (rd_state_next == RD_IDLE) && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_reg <= s_axi_araddr;
      end
      if (rd_state_reg == RD_FETCH) begin
        rd_err_reg <= !rd_hit;
      end
      // The store registers its data on the fetch edge, so answer one edge later
      if (rd_state_reg == RD_LOAD) begin
        s_axi_rvalid <= 1'b1;
        // A refused address answers zero, never a word picked by its index bits
        s_axi_rdata <= rd_err_reg ? 32'h00000000 : {16'h0000, mem_rd_data}; // [RULE_05]
        s_axi_rresp <= rd_err_reg ? `IPR_RESP_SLVERR : `IPR_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  // Strobes 1:0 cover the 16 meaningful bits; strobes 3:2 have nothing to gate
  ipr_reg_mem #(
    .WIDTH(16)
  ) ipr_reg_mem_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_fire && wr_hit),
    .wr_idx(wr_idx),
    .wr_data(w_data_reg[15:0]),
    .wr_strb_mask({{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}}),
    .rd_en(rd_state_reg == RD_FETCH),
    .rd_idx(rd_idx),
    .rd_data(mem_rd_data),
    .all_words(words)
  );

  // ----------------------------------------------------------------
  // Level outputs to arbitration, re-registered so outputs come from flops
  // ----------------------------------------------------------------
  // One cycle behind the store: a write shows here the edge after it lands
  always @(posedge aclk) begin
    if (!aresetn) begin
      // Level 4 on reset, matching the reset image of the store
      timer1_prio <= `IPR_FLD_RESET; // [RULE_04]
      compare1_prio <= `IPR_FLD_RESET;
      capture1_prio <= `IPR_FLD_RESET;
      ext_irq0_prio <= `IPR_FLD_RESET;
      timer2_prio <= `IPR_FLD_RESET;
      compare2_prio <= `IPR_FLD_RESET;
      capture2_prio <= `IPR_FLD_RESET;
      serial1_rx_prio <= `IPR_FLD_RESET;
      spi_port1_event_prio <= `IPR_FLD_RESET;
      spi_port1_fault_prio <= `IPR_FLD_RESET;
      timer3_prio <= `IPR_FLD_RESET;
      adc_done_prio <= `IPR_FLD_RESET;
      serial1_tx_prio <= `IPR_FLD_RESET;
      pin_change_prio <= `IPR_FLD_RESET;
      comparator_prio <= `IPR_FLD_RESET;
      i2c_port1_master_prio <= `IPR_FLD_RESET;
      i2c_port1_slave_prio <= `IPR_FLD_RESET;
      ext_irq1_prio <= `IPR_FLD_RESET;
    end else begin
      // priority_ctrl_0: timer1, compare1, capture1, ext irq0
      timer1_prio <= fld(words, 3'h0, `IPR_FLD_HI); // [RULE_06] [RULE_14]
      compare1_prio <= fld(words, 3'h0, `IPR_FLD_MH); // [RULE_06]
      capture1_prio <= fld(words, 3'h0, `IPR_FLD_ML); // [RULE_06]
      ext_irq0_prio <= fld(words, 3'h0, `IPR_FLD_LO); // [RULE_06]
      // priority_ctrl_1: timer2, compare2, capture2
      timer2_prio <= fld(words, 3'h1, `IPR_FLD_HI); // [RULE_07]
      compare2_prio <= fld(words, 3'h1, `IPR_FLD_MH); // [RULE_07]
      capture2_prio <= fld(words, 3'h1, `IPR_FLD_ML); // [RULE_07]
      // priority_ctrl_2: serial1 rx, spi1 event, spi1 fault, timer3
      serial1_rx_prio <= fld(words, 3'h2, `IPR_FLD_HI); // [RULE_08]
      spi_port1_event_prio <= fld(words, 3'h2, `IPR_FLD_MH); // [RULE_08]
      spi_port1_fault_prio <= fld(words, 3'h2, `IPR_FLD_ML); // [RULE_08]
      timer3_prio <= fld(words, 3'h2, `IPR_FLD_LO); // [RULE_08]
      // priority_ctrl_3: adc done, serial1 tx
      adc_done_prio <= fld(words, 3'h3, `IPR_FLD_ML); // [RULE_09]
      serial1_tx_prio <= fld(words, 3'h3, `IPR_FLD_LO); // [RULE_09]
      // priority_ctrl_4: pin change, comparator, i2c1 master, i2c1 slave
      pin_change_prio <= fld(words, 3'h4, `IPR_FLD_HI); // [RULE_10]
      comparator_prio <= fld(words, 3'h4, `IPR_FLD_MH); // [RULE_10]
      i2c_port1_master_prio <= fld(words, 3'h4, `IPR_FLD_ML); // [RULE_10]
      i2c_port1_slave_prio <= fld(words, 3'h4, `IPR_FLD_LO); // [RULE_10]
      // priority_ctrl_5: ext irq1 only
      ext_irq1_prio <= fld(words, 3'h5, `IPR_FLD_LO); // [RULE_11]
    end
  end

  // ----------------------------------------------------------------
  // Per-source enable: level code is passed unchanged, 111 highest, 001 lowest
  // ----------------------------------------------------------------
  // Any nonzero code may request; 000 blocks the source entirely
  always @(posedge aclk) begin
    if (!aresetn) begin
      source_enabled <= {18{1'b1}};
    end else begin
      source_enabled <= {
        // priority_ctrl_5 supplies the top bit
        fld(words, 3'h5, `IPR_FLD_LO) != `IPR_LVL_OFF,
        // priority_ctrl_4
        fld(words, 3'h4, `IPR_FLD_LO) != `IPR_LVL_OFF,
        fld(words, 3'h4, `IPR_FLD_ML) != `IPR_LVL_OFF,
        fld(words, 3'h4, `IPR_FLD_MH) != `IPR_LVL_OFF,
        fld(words, 3'h4, `IPR_FLD_HI) != `IPR_LVL_OFF,
        // priority_ctrl_3
        fld(words, 3'h3, `IPR_FLD_LO) != `IPR_LVL_OFF,
        fld(words, 3'h3, `IPR_FLD_ML) != `IPR_LVL_OFF,
        // priority_ctrl_2
        fld(words, 3'h2, `IPR_FLD_LO) != `IPR_LVL_OFF,
        fld(words, 3'h2, `IPR_FLD_ML) != `IPR_LVL_OFF,
        fld(words, 3'h2, `IPR_FLD_MH) != `IPR_LVL_OFF,
        fld(words, 3'h2, `IPR_FLD_HI) != `IPR_LVL_OFF,
        // priority_ctrl_1
        fld(words, 3'h1, `IPR_FLD_ML) != `IPR_LVL_OFF,
        fld(words, 3'h1, `IPR_FLD_MH) != `IPR_LVL_OFF,
        fld(words, 3'h1, `IPR_FLD_HI) != `IPR_LVL_OFF,
        // priority_ctrl_0 supplies the low four bits, timer1 at bit 0
        fld(words, 3'h0, `IPR_FLD_LO) != `IPR_LVL_OFF,
        fld(words, 3'h0, `IPR_FLD_ML) != `IPR_LVL_OFF,
        fld(words, 3'h0, `IPR_FLD_MH) != `IPR_LVL_OFF,
        fld(words, 3'h0, `IPR_FLD_HI) != `IPR_LVL_OFF
      }; // [RULE_01] [RULE_02] [RULE_03] [RULE_13]
    end
  end

endmodule

// >>> dv/ipr_top_props.sv
// Concurrent checks on the priority register bank ports
`timescale 1ns/1ps

module ipr_top_props #(
  parameter ADDR_W = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] timer1_prio,
  input wire [2:0] adc_done_prio,
  input wire [2:0] ext_irq1_prio,
  input wire [17:0] source_enabled
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Sampled levels of three sources spread over the bank
  wire [8:0] lvl = {timer1_prio, adc_done_prio, ext_irq1_prio};

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  chk_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read answer late");
  chk_write_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_read_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("unused read bits not zero");

  // ----------------------------------------------------------------
  // Level outputs
  // ----------------------------------------------------------------
  chk_reset_level: assert property (
    $rose(aresetn) |-> lvl == 9'h124 && source_enabled == 18'h3FFFF)
    else $error("levels not at default after reset");
  // Enable flags and levels update on the same edge; the check still only runs while the levels are stable
  chk_enable_flag: assert property (
    $stable(lvl) |-> source_enabled[0] == (timer1_prio != 3'h0)
      && source_enabled[11] == (adc_done_prio != 3'h0)
      && source_enabled[17] == (ext_irq1_prio != 3'h0))
    else $error("enable flag disagrees with level");
  chk_level_cause: assert property (
    !$stable(lvl) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("level changed without a write");

  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
  cover property (!source_enabled[17]);
endmodule

bind ipr_top ipr_top_props #(.ADDR_W(ADDR_W)) ipr_top_props_inst (.*);

// >>> dv/ipr_top_tb.sv
// Self-checking bench for the priority register bank over AXI4-Lite
`timescale 1ns/1ps
`include "ipr_defines.vh"

`define CHK(g, e, s) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t %s got %0h exp %0h", $time, s, g, e); end end

module ipr_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] timer1_prio, compare1_prio, capture1_prio, ext_irq0_prio, timer2_prio;
  logic [2:0] compare2_prio, capture2_prio, serial1_rx_prio, spi_port1_event_prio;
  logic [2:0] spi_port1_fault_prio, timer3_prio, adc_done_prio, serial1_tx_prio;
  logic [2:0] pin_change_prio, comparator_prio, i2c_port1_master_prio, i2c_port1_slave_prio;
  logic [2:0] ext_irq1_prio;
  logic [17:0] source_enabled;
  logic [15:0] m [6];
  int checks = 0;
  int error_cnt = 0;
  localparam logic [15:0] MSK [6] = '{`IPR_MSK_CTRL0, `IPR_MSK_CTRL1, `IPR_MSK_CTRL2,
    `IPR_MSK_CTRL3, `IPR_MSK_CTRL4, `IPR_MSK_CTRL5};
  localparam logic [15:0] RST [6] = '{16'h4444, 16'h4440, 16'h4444, 16'h0044, 16'h4444, 16'h0004};
  // Field codes chosen so every level 0..7 appears somewhere
  localparam logic [31:0] PAT [6] = '{32'h7531, 32'h642F, 32'h0123, 32'hFF56, 32'h4567, 32'hFFF0};

  // All levels, timer1 in the low bits, same order as source_enabled
  wire [53:0] outs = {ext_irq1_prio, i2c_port1_slave_prio, i2c_port1_master_prio,
    comparator_prio, pin_change_prio, serial1_tx_prio, adc_done_prio, timer3_prio,
    spi_port1_fault_prio, spi_port1_event_prio, serial1_rx_prio, capture2_prio,
    compare2_prio, timer2_prio, ext_irq0_prio, capture1_prio, compare1_prio, timer1_prio};

  ipr_top ipr_top_inst (.*);

  initial forever #2 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("[ERR] %0t no answer from slave", $time);
    summarize();
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang();
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang();
  endtask

  // Masked write into the shadow copy; reserved bits never land
  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    logic [15:0] be;
    be = {{8{s[1]}}, {8{s[0]}}} & MSK[i];
    axi_wr(5'(4 * i), d, s, r);
    m[i] = (m[i] & ~be) | (d[15:0] & be);
    `CHK(r, `IPR_RESP_OKAY, "bresp")
  endtask

  task automatic rd_all();
    logic [1:0] r;
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      axi_rd(5'(4 * i), q, r);
      `CHK(q, {16'h0000, m[i]}, "rdata")
      `CHK(r, `IPR_RESP_OKAY, "rresp")
    end
  endtask

  // Levels lag the store by a clock, so let two edges pass first
  task automatic check_outs();
    logic [53:0] f;
    logic [17:0] en;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    f = {m[5][2:0], m[4][2:0], m[4][6:4], m[4][10:8], m[4][14:12], m[3][2:0], m[3][6:4],
      m[2][2:0], m[2][6:4], m[2][10:8], m[2][14:12], m[1][6:4], m[1][10:8], m[1][14:12],
      m[0][2:0], m[0][6:4], m[0][10:8], m[0][14:12]};
    for (int i = 0; i < 18; i++) en[i] = |f[3 * i +: 3];
    `CHK(outs, f, "levels")
    `CHK(source_enabled, en, "enables")
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] r;
    logic [31:0] q;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    m = RST;
    check_outs();
    rd_all();
    $display("test reset values done");
    for (int i = 0; i < 6; i++) wr(i, 32'hFFFFFFFF, 4'hF);
    check_outs();
    rd_all();
    $display("test all ones done");
    for (int i = 0; i < 6; i++) wr(i, PAT[i], 4'hF);
    check_outs();
    rd_all();
    $display("test field codes done");
    wr(0, 32'h00001111, 4'h1);
    wr(2, 32'h00007700, 4'h2);
    check_outs();
    rd_all();
    $display("test byte strobes done");
    axi_wr(5'h18, 32'h00000000, 4'hF, r);
    `CHK(r, `IPR_RESP_SLVERR, "unmapped bresp")
    axi_wr(5'h01, 32'h00000000, 4'hF, r);
    `CHK(r, `IPR_RESP_SLVERR, "misaligned bresp")
    axi_rd(5'h1C, q, r);
    `CHK(q, 32'h00000000, "unmapped rdata")
    `CHK(r, `IPR_RESP_SLVERR, "unmapped rresp")
    axi_rd(5'h05, q, r);
    `CHK(q, 32'h00000000, "misaligned rdata")
    `CHK(r, `IPR_RESP_SLVERR, "misaligned rresp")
    check_outs();
    rd_all();
    $display("test unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    m = RST;
    check_outs();
    rd_all();
    $display("test second reset done");
    summarize();
  end
endmodule
